// ### aums_pkg.sv
// shared constants for the auxiliary under-voltage and measurement status registers
package aums_pkg;
  // register word indices; byte address is four times the index
  localparam logic [13:0] AUMS_IDX_UV = 14'h1829;
  localparam logic [13:0] AUMS_IDX_MEAS = 14'h183E;
  localparam logic [13:0] AUMS_IDX_CTRL = 14'h1840;
  // index windows whose reads retire the ready flags
  localparam logic [13:0] AUMS_IDX_SAFE_LO = 14'h1900;
  localparam logic [13:0] AUMS_IDX_SAFE_HI = 14'h190F;
  localparam logic [13:0] AUMS_IDX_PER_LO = 14'h1A00;
  localparam logic [13:0] AUMS_IDX_PER_HI = 14'h1A3F;
  // bus widths
  localparam int AUMS_AW = 16;
  localparam int AUMS_DW = 32;
  // under-voltage register layout
  localparam int AUMS_NUV = 5;
  localparam int AUMS_UV_EXTRA = 4;
  // measurement status layout
  localparam int AUMS_MS_FLT_LSB = 12;
  localparam int AUMS_MS_SYNC = 9;
  localparam int AUMS_MS_PER = 8;
  localparam int AUMS_NCH = 6;
  localparam int AUMS_NFLT = 4;
  // control register layout
  localparam int AUMS_CTRL_MODE = 0;
  // reset values
  localparam logic [15:0] AUMS_UV_RST = 16'h0000;
  localparam logic [15:0] AUMS_MEAS_RST = 16'h0000;
  localparam logic [15:0] AUMS_CTRL_RST = 16'h0000;
  // samples needed before an application result may be captured
  localparam int AUMS_SAMPLES_MIN = 16;
  // periodic update modes
  typedef enum logic {
    AUMS_PER_AUTO,
    AUMS_PER_ONCE
  } aums_per_mode_t;
endpackage

// ### aums_flag.sv
// sticky status flag where a new event outranks a clear
`timescale 1ns/100ps
module aums_flag (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event and clear
  input wire logic set_i,
  input wire logic clr_i,
  // flag state
  output logic flag
);
  logic flag_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag = flag_q;
endmodule // aums_flag

// ### aums_cnt.sv
// per-input sample counter that reports when enough samples are held
`timescale 1ns/100ps
module aums_cnt #(
  parameter int THRESH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sample and capture events
  input wire logic sample_i,
  input wire logic capture_i,
  // ready state
  output logic ready
);
  localparam int W = $clog2(THRESH + 1);
  localparam logic [W-1:0] TOP = W'(THRESH);
  logic [W-1:0] cnt_q;

  // count samples, saturate at the threshold, restart on capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (capture_i) begin
      cnt_q <= sample_i ? W'(1) : '0;
    end else if (sample_i && cnt_q != TOP) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign ready = (cnt_q >= TOP);
endmodule // aums_cnt

// ### aums_regs.sv
// apb status register bank for auxiliary under-voltage and measurement state
//
// Summary of operation
// - bit 4 of the under-voltage register at index 1829h is the extra input flag, cleared by a read.
// - bits 3 to 0 of that register are the latched flags of inputs 3 to 0, cleared by a read.
// - an under-voltage flag reads 1 once seen and 0 otherwise, and is 0 after reset.
// - bits 15 to 5 of the under-voltage register read zero and ignore writes.
// - bit 15 of the measurement status at index 183Eh shows a measurement fault, 0 after reset.
// - bit 14 shows a communication fault, 0 after reset.
// - bit 13 shows an analog fault, 0 after reset.
// - bit 12 shows a supply error, 0 after reset.
// - bits 11 and 10 of the measurement status read zero.
// - bit 9 sets on synchronous results and clears on any read in the safety result window.
// - bit 8 sets on periodic results and clears by a window read in auto mode or a once write in once mode.
// - bits 5 to 0 read 1 once an input has at least 16 samples, else 0.
`timescale 1ns/100ps
module aums_regs
  import aums_pkg::*;
#(
  parameter int NCH = AUMS_NCH,
  parameter int SAMPLES = AUMS_SAMPLES_MIN
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AUMS_AW-1:0] paddr,
  input wire logic [AUMS_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  // apb answer
  output logic pready,
  output logic [AUMS_DW-1:0] prdata,
  output logic pslverr,
  // asynchronous detector levels: bits 3..0 inputs 3..0, bit 4 extra input
  input wire logic [AUMS_NUV-1:0] uv_level,
  // asynchronous fault levels
  input wire logic measurement_fault_level,
  input wire logic communication_fault_level,
  input wire logic analog_fault_level,
  input wire logic supply_fault_level,
  // same-clock result events
  input wire logic sync_done_pulse,
  input wire logic periodic_done_pulse,
  // same-clock per-channel sample and capture events, indexed by status bit
  input wire logic [NCH-1:0] sample_pulse,
  input wire logic [NCH-1:0] capture_pulse
);
  localparam int NSY = AUMS_NUV + AUMS_NFLT;

  // synchroniser stages
  logic [NSY-1:0] meta_q;
  logic [NSY-1:0] sync_q;
  // bus answer registers
  logic pready_q;
  logic [AUMS_DW-1:0] prdata_q;
  logic pslverr_q;
  // control state
  aums_per_mode_t mode_q;
  // flag states
  logic [AUMS_NUV-1:0] uv_flag;
  logic sync_rdy;
  logic per_rdy;
  logic [NCH-1:0] ch_rdy;
  // decode
  logic [13:0] idx;
  logic acc;
  logic take;
  logic done;
  logic rd_done;
  logic wr_done;
  logic hit_uv;
  logic hit_meas;
  logic hit_ctrl;
  logic in_safe;
  logic in_per;
  logic mapped;
  // read words and clear terms
  logic [15:0] uv_word;
  logic [15:0] meas_word;
  logic [15:0] ctrl_word;
  logic [15:0] rd_word;
  logic [AUMS_NUV-1:0] uv_clr;
  logic sync_clr;
  logic per_clr;
  logic once_wr;
  logic [AUMS_NFLT-1:0] flt;

  // two-stage synchroniser for the asynchronous levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {measurement_fault_level, communication_fault_level,
                 analog_fault_level, supply_fault_level, uv_level};
      sync_q <= meta_q;
    end
  end

  // fault summary in register order 15..12
  assign flt = sync_q[NSY-1:AUMS_NUV];

  // apb phase decode
  assign idx = paddr[AUMS_AW-1:2];
  assign acc = psel & penable;
  assign take = acc & ~pready_q;
  assign done = acc & pready_q;
  assign rd_done = done & ~pwrite;
  assign wr_done = done & pwrite;

  // address decode
  assign hit_uv = (idx == AUMS_IDX_UV);
  assign hit_meas = (idx == AUMS_IDX_MEAS);
  assign hit_ctrl = (idx == AUMS_IDX_CTRL);
  assign in_safe = (idx >= AUMS_IDX_SAFE_LO) && (idx <= AUMS_IDX_SAFE_HI);
  assign in_per = (idx >= AUMS_IDX_PER_LO) && (idx <= AUMS_IDX_PER_HI);
  assign mapped = hit_uv | hit_meas | hit_ctrl | in_safe | in_per;

  // one wait state: take in the first access cycle, complete in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= take;
    end
  end

  // read data and error captured when the request is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (take) begin
      prdata_q <= pwrite ? '0 : {16'h0000, rd_word};
      pslverr_q <= ~mapped;
    end else if (done) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // under-voltage word; upper bits tied low and never written
  always_comb begin
    uv_word = AUMS_UV_RST;
    uv_word[AUMS_NUV-1:0] = uv_flag;
  end

  // measurement status word
  always_comb begin
    meas_word = AUMS_MEAS_RST;
    meas_word[AUMS_MS_FLT_LSB +: AUMS_NFLT] = flt;
    meas_word[AUMS_MS_SYNC] = sync_rdy;
    meas_word[AUMS_MS_PER] = per_rdy;
    meas_word[NCH-1:0] = ch_rdy;
  end

  // control word shows the periodic update mode
  always_comb begin
    ctrl_word = AUMS_CTRL_RST;
    ctrl_word[AUMS_CTRL_MODE] = mode_q;
  end

  // read multiplexer; result windows read zero here
  always_comb begin
    if (hit_uv) begin
      rd_word = uv_word;
    end else if (hit_meas) begin
      rd_word = meas_word;
    end else if (hit_ctrl) begin
      rd_word = ctrl_word;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // periodic update mode, written through the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= AUMS_PER_AUTO;
    end else if (wr_done && hit_ctrl && pstrb[0]) begin
      mode_q <= aums_per_mode_t'(pwdata[AUMS_CTRL_MODE]);
    end
  end

  // only bits that were returned as set are cleared, so later events survive
  assign uv_clr = (rd_done && hit_uv) ? prdata_q[AUMS_NUV-1:0] : '0;

  // synchronous ready retires on any read of the safety window
  assign sync_clr = rd_done & in_safe;

  // periodic ready retires by window read in auto mode or once write in once mode
  assign once_wr = wr_done & hit_ctrl & pstrb[0] &
                   (pwdata[AUMS_CTRL_MODE] == AUMS_PER_ONCE);
  assign per_clr = (mode_q == AUMS_PER_AUTO) ? (rd_done & in_per)
                                             : once_wr;

  // sticky under-voltage flags, set while the synced level is high
  for (genvar i = 0; i < AUMS_NUV; i++) begin : g_uv
    aums_flag u_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set_i(sync_q[i]),
      .clr_i(uv_clr[i]),
      .flag(uv_flag[i])
    );
  end

  // synchronous result ready flag
  aums_flag u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(sync_done_pulse),
    .clr_i(sync_clr),
    .flag(sync_rdy)
  );

  // periodic result ready flag
  aums_flag u_per (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(periodic_done_pulse),
    .clr_i(per_clr),
    .flag(per_rdy)
  );

  // per-channel application readiness from sample counts
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    aums_cnt #(
      .THRESH(SAMPLES)
    ) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .sample_i(sample_pulse[c]),
      .capture_i(capture_pulse[c]),
      .ready(ch_rdy[c])
    );
  end
endmodule // aums_regs

// ### aums_regs_checker.sv
// concurrent checks on the status register bank ports
`timescale 1ns/100ps
module aums_regs_checker
  import aums_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AUMS_AW-1:0] paddr,
  input wire logic pready,
  input wire logic [AUMS_DW-1:0] prdata,
  input wire logic pslverr,
  // status sources
  input wire logic [AUMS_NUV-1:0] uv_level,
  input wire logic measurement_fault_level,
  input wire logic communication_fault_level,
  input wire logic analog_fault_level,
  input wire logic supply_fault_level,
  input wire logic sync_done_pulse,
  input wire logic periodic_done_pulse
);
  logic [13:0] idx;
  logic [3:0] flt;
  logic rd_uv;
  logic rd_ms;
  logic mapped;
  logic [3:0] age_q;
  // decode of the answered access
  assign idx = paddr[15:2];
  assign flt = {measurement_fault_level, communication_fault_level,
                analog_fault_level, supply_fault_level};
  assign rd_uv = pready && !pwrite && idx == AUMS_IDX_UV;
  assign rd_ms = pready && !pwrite && idx == AUMS_IDX_MEAS;
  assign mapped = idx == AUMS_IDX_UV || idx == AUMS_IDX_MEAS || idx == AUMS_IDX_CTRL
    || (idx >= AUMS_IDX_SAFE_LO && idx <= AUMS_IDX_SAFE_HI)
    || (idx >= AUMS_IDX_PER_LO && idx <= AUMS_IDX_PER_HI);
  // edges since reset release, so synchroniser lag is past
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    pready ##1 !pready;
  endsequence
  AST_ANSWER: assert property (s_acc |=> s_done)
    else $error("no single-cycle answer");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_ERR: assert property (pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
    else $error("bad error response");
  AST_UV_RSVD: assert property (rd_uv |-> prdata[31:5] == 27'h0)
    else $error("uv reserved bits set");
  AST_MS_RSVD: assert property (rd_ms |-> prdata[11:10] == 2'h0 && prdata[31:16] == 16'h0)
    else $error("meas reserved bits set");
  AST_FLT: assert property (rd_ms && age_q > 4'h8 && $past(flt, 1) == $past(flt, 4)
    && $past(flt, 2) == $past(flt, 5) && $past(flt, 3) == $past(flt, 1)
    |-> prdata[15:12] == $past(flt, 1)) else $error("fault bits wrong");
  AST_UV_SET: assert property (rd_uv && age_q > 4'h8
    |-> (prdata[4:0] & $past(uv_level, 3) & $past(uv_level, 4) & $past(uv_level, 5))
    == ($past(uv_level, 3) & $past(uv_level, 4) & $past(uv_level, 5)))
    else $error("uv flag lost");
  AST_SYNC: assert property (rd_ms && $past(sync_done_pulse, 2) |-> prdata[9])
    else $error("sync ready lost");
  AST_PER: assert property (rd_ms && $past(periodic_done_pulse, 2) |-> prdata[8])
    else $error("periodic ready lost");
endmodule // aums_regs_checker

bind aums_regs aums_regs_checker aums_regs_checker_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .uv_level, .measurement_fault_level,
  .communication_fault_level, .analog_fault_level, .supply_fault_level,
  .sync_done_pulse, .periodic_done_pulse);

// ### aums_regs_tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/100ps
module aums_regs_tb_top;
  import aums_pkg::*;
  localparam int SMP = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [4:0] uv_level = 5'h00;
  logic [3:0] flt = 4'h0;
  logic sync_p = 1'b0;
  logic per_p = 1'b0;
  logic [5:0] smp_p = 6'h00;
  logic [5:0] cap_p = 6'h00;
  logic [15:0] seed = 16'h94B3;
  logic [4:0] v;
  logic [31:0] rdat;
  logic err;
  int errors = 0;
  int n_checks = 0;
  aums_regs #(.NCH(6), .SAMPLES(SMP)) aums_regs_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .uv_level(uv_level), .measurement_fault_level(flt[3]),
    .communication_fault_level(flt[2]), .analog_fault_level(flt[1]),
    .supply_fault_level(flt[0]), .sync_done_pulse(sync_p), .periodic_done_pulse(per_p),
    .sample_pulse(smp_p), .capture_pulse(cap_p));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected measurement status word
  function automatic logic [31:0] ms(input logic [3:0] f, input logic s, input logic p,
                                     input logic [5:0] r);
    return {16'h0, f, 2'b00, s, p, 2'b00, r};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until the rising edge that samples ready high
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    // answer taken at the completion edge, then the request is released
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(rdat, e);
  endtask
  task automatic test_done;
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    cyc(5000);
    errors++;
    test_done;
  end
  // main sequence
  initial begin
    cyc(10);
    presetn <= 1'b1;
    rd(AUMS_IDX_UV, 32'h0);
    rd(AUMS_IDX_MEAS, 32'h0);
    apb(1'b1, AUMS_IDX_UV, {seed, seed});
    rd(AUMS_IDX_UV, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 5'h10 : (i == 1) ? 5'h0F : seed[4:0];
      uv_level <= v;
      cyc(4);
      uv_level <= 5'h00;
      cyc(3);
      rd(AUMS_IDX_UV, {27'h0, v});
      rd(AUMS_IDX_UV, 32'h0);
    end
    // detection held across clearing reads
    uv_level <= 5'h1F;
    cyc(4);
    rd(AUMS_IDX_UV, 32'h1F);
    rd(AUMS_IDX_UV, 32'h1F);
    uv_level <= 5'h00;
    cyc(3);
    rd(AUMS_IDX_UV, 32'h1F);
    rd(AUMS_IDX_UV, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      flt <= (i == 0) ? 4'hF : seed[3:0];
      cyc(3);
      rd(AUMS_IDX_MEAS, ms(flt, 1'b0, 1'b0, 6'h00));
    end
    flt <= 4'h0;
    // synchronous and periodic ready
    sync_p <= 1'b1;
    per_p <= 1'b1;
    cyc(1);
    sync_p <= 1'b0;
    per_p <= 1'b0;
    rd(AUMS_IDX_MEAS, ms(4'h0, 1'b1, 1'b1, 6'h00));
    rd(AUMS_IDX_SAFE_HI, 32'h0);
    rd(AUMS_IDX_MEAS, ms(4'h0, 1'b0, 1'b1, 6'h00));
    rd(AUMS_IDX_PER_LO, 32'h0);
    rd(AUMS_IDX_MEAS, 32'h0);
    apb(1'b1, AUMS_IDX_CTRL, 32'h1);
    per_p <= 1'b1;
    cyc(1);
    per_p <= 1'b0;
    rd(AUMS_IDX_PER_HI, 32'h0);
    rd(AUMS_IDX_MEAS, ms(4'h0, 1'b0, 1'b1, 6'h00));
    apb(1'b1, AUMS_IDX_CTRL, 32'h1);
    rd(AUMS_IDX_MEAS, 32'h0);
    apb(1'b1, AUMS_IDX_CTRL, 32'h0);
    // sample counts around the threshold
    for (int i = 0; i < SMP; i++) begin
      rd(AUMS_IDX_MEAS, 32'h0);
      smp_p <= 6'h3F;
      cyc(1);
      smp_p <= 6'h00;
    end
    rd(AUMS_IDX_MEAS, 32'h3F);
    cap_p <= 6'h3F;
    cyc(1);
    cap_p <= 6'h00;
    rd(AUMS_IDX_MEAS, 32'h0);
    apb(1'b0, 14'h0001, 32'h0);
    chk({err, rdat[30:0]}, 32'h8000_0000);
    test_done;
  end
endmodule // aums_regs_tb_top
